// ===== mld_host.sv
// Host loader: sends one 32-bit slot word as eight nibble pulses per strobe
`timescale 1ns/1ns
`default_nettype none

module mld_host
	import mld_pkg::*;
#(
	parameter int unsigned PHASE_HALF_CYC = PHASE_HALF_CYC_DEF
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	// Timebase choice: high makes the host drive the phase pin
	input  wire logic               drive_phase,
	// Slot word
	input  wire logic [LATCH_W-1:0] slot_word,
	input  wire logic               slot_valid,
	output logic                    slot_ready,
	output logic                    refresh_req,
	// Link
	mld_link_if.host                lnk
);

	// ************************************************************
	// Phase timebase and strobe sense
	// ************************************************************
	logic [31:0] ph_cnt_q;
	logic [31:0] ph_cnt_d;
	logic        ph_q;
	logic        ph_d;
	logic        oe_q;
	logic        sy_strobe;
	logic        strobe_prev_q;
	logic        rise;

	mld_sync2 #(.W(1)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.d     (lnk.strobe),
		.q     (sy_strobe)
	);

	// Even split of the period keeps the strobe at half duty
	always_comb begin
		ph_cnt_d = ph_cnt_q + 32'h1;
		ph_d     = ph_q;
		if (!drive_phase) begin
			ph_cnt_d = '0;
		end else if (ph_cnt_q >= PHASE_HALF_CYC - 1) begin
			ph_cnt_d = '0;
			ph_d     = ~ph_q;
		end
		rise = sy_strobe & ~strobe_prev_q;
	end

	// ************************************************************
	// Pulse sequencer
	// ************************************************************
	mld_host_st_t      st_q;
	mld_host_st_t      st_d;
	logic [7:0]        cnt_q;
	logic [7:0]        cnt_d;
	logic [SLOT_W-1:0] pls_q;
	logic [SLOT_W-1:0] pls_d;
	logic [LATCH_W-1:0] word_q;
	logic [LATCH_W-1:0] word_d;
	logic [NIB_W-1:0]  nib_q;
	logic [NIB_W-1:0]  nib_d;
	logic              lclk_q;
	logic              lclk_d;

	// Data changes only at the rising clock edge, a half period from
	// the fall on either side, which covers setup and hold
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		pls_d  = pls_q;
		word_d = word_q;
		nib_d  = nib_q;
		lclk_d = lclk_q;
		case (st_q)
			MLD_IDLE: begin
				if (slot_valid) begin
					word_d = slot_word;
					st_d   = MLD_WAIT;
				end
			end
			MLD_WAIT: begin
				if (rise) begin
					st_d   = MLD_HIGH;
					lclk_d = 1'b1;
					nib_d  = word_q[NIB_W-1:0];
					pls_d  = SLOT_FIRST;
					cnt_d  = '0;
				end
			end
			MLD_HIGH: begin
				cnt_d = cnt_q + 8'h1;
				if (cnt_q == LINK_LAST) begin
					lclk_d = 1'b0;
					cnt_d  = '0;
					st_d   = MLD_LOW;
				end
			end
			MLD_LOW: begin
				cnt_d = cnt_q + 8'h1;
				if (cnt_q == LINK_LAST) begin
					cnt_d = '0;
					if (pls_q == SLOT_LAST) begin
						st_d = MLD_IDLE;
					end else begin
						pls_d  = pls_q + 3'h1;
						nib_d  = word_q[{pls_d, 2'b00} +: NIB_W];
						lclk_d = 1'b1;
						st_d   = MLD_HIGH;
					end
				end
			end
			default: begin
				st_d = MLD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_cnt_q      <= '0;
			ph_q          <= 1'b0;
			oe_q          <= 1'b0;
			strobe_prev_q <= 1'b0;
			refresh_req   <= 1'b0;
			st_q          <= MLD_IDLE;
			cnt_q         <= '0;
			pls_q         <= SLOT_FIRST;
			word_q        <= LATCH_RST;
			nib_q         <= 4'h0;
			lclk_q        <= 1'b0;
		end else if (ce) begin
			ph_cnt_q      <= ph_cnt_d;
			ph_q          <= ph_d;
			oe_q          <= drive_phase;
			strobe_prev_q <= sy_strobe;
			refresh_req   <= rise;
			st_q          <= st_d;
			cnt_q         <= cnt_d;
			pls_q         <= pls_d;
			word_q        <= word_d;
			nib_q         <= nib_d;
			lclk_q        <= lclk_d;
		end
	end

	assign slot_ready             = (st_q == MLD_IDLE);
	assign lnk.link_clk           = lclk_q;
	assign lnk.nibble_data_inputs = nib_q;
	assign lnk.phase_drv          = ph_q;
	assign lnk.phase_oe           = oe_q;

endmodule // mld_host

`default_nettype wire

// ===== mld_pkg.sv
// Shared constants for the parallel matrix LCD driver and its host loader
package mld_pkg;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int NIB_W    = 4;
	localparam int SLOTS    = 8;
	localparam int LATCH_W  = NIB_W * SLOTS;
	localparam int ROWS     = 8;
	localparam int COLS_RC  = 23;
	localparam int COLS     = 32;
	localparam int SLOT_W   = 3;

	localparam logic [SLOT_W-1:0]  SLOT_FIRST = 3'h0;
	localparam logic [SLOT_W-1:0]  SLOT_LAST  = 3'h7;
	localparam logic [LATCH_W-1:0] LATCH_RST  = 32'h0000_0000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS        = 4;
	// Fastest legal input clock is 1.0 MHz, so each half lasts 500 ns
	localparam int LINK_HALF_NS  = 500;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] LINK_LAST = 8'(LINK_HALF_CYC - 1);

	// Phase half period for a 240 Hz strobe (30 Hz times eight rows)
	localparam int PHASE_HALF_US      = 2083;
	localparam int PHASE_HALF_CYC_DEF = PHASE_HALF_US * 1000 / CLK_NS;

	typedef enum logic [1:0] {
		MLD_IDLE,
		MLD_WAIT,
		MLD_HIGH,
		MLD_LOW
	} mld_host_st_t;

endpackage

// ===== mld_link_if.sv
// Pin bundle between the LCD driver and its host loader
`timescale 1ns/1ns
`default_nettype none

interface mld_link_if;
	logic             link_clk;
	logic [3:0]       nibble_data_inputs;
	logic             phase_drv;
	logic             phase_oe;
	logic             phase_osc;
	logic             lcd_phase_input;
	logic             strobe;

	// Host drive wins over the RC oscillator the bench models
	assign lcd_phase_input = phase_oe ? phase_drv : phase_osc;

	modport dev (
		input  link_clk,
		input  nibble_data_inputs,
		input  lcd_phase_input,
		output strobe
	);

	modport host (
		output link_clk,
		output nibble_data_inputs,
		output phase_drv,
		output phase_oe,
		input  strobe
	);
endinterface

`default_nettype wire

// ===== mld_sync2.sv
// Two flip-flop synchroniser for levels entering the clk domain
`timescale 1ns/1ns
`default_nettype none

module mld_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			q    <= '0;
		end else if (ce) begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
endmodule // mld_sync2

`default_nettype wire

// ===== mld_device.sv
// Dot matrix LCD driver: nibble latches, holding latches and AC drive phase
`timescale 1ns/1ns
`default_nettype none

module mld_device
	import mld_pkg::*;
#(
	parameter bit COL_ONLY = 1'b0
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            ce,
	// Phase pin mode: high when the pin free-runs as an oscillator
	input  wire logic            osc_mode,
	// Link
	mld_link_if.dev              lnk,
	// Drive outputs
	output logic [ROWS-1:0]      row_mid,
	output logic [ROWS-1:0]      row_lvl,
	output logic [COLS-1:0]      column_drive_outputs
);

	// ************************************************************
	// Link domain capture
	// ************************************************************
	logic [NIB_W-1:0] cap_nib_q;
	logic [NIB_W-1:0] cap_nib_d;
	logic             pulse_tgl_q;
	logic             pulse_tgl_d;

	// The nibble is sampled only on the falling clock edge and held until the next fall
	always_comb begin
		cap_nib_d   = lnk.nibble_data_inputs;
		pulse_tgl_d = ~pulse_tgl_q;
	end

	always_ff @(negedge lnk.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_nib_q   <= 4'h0;
			pulse_tgl_q <= 1'b0;
		end else begin
			cap_nib_q   <= cap_nib_d;
			pulse_tgl_q <= pulse_tgl_d;
		end
	end

	// ************************************************************
	// Crossings into clk
	// ************************************************************
	logic sy_tgl;
	logic sy_phase;

	mld_sync2 #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.d     ({pulse_tgl_q, lnk.lcd_phase_input}),
		.q     ({sy_tgl, sy_phase})
	);

	// ************************************************************
	// Slot counter, latches and strobe
	// ************************************************************
	logic                tgl_seen_q;
	logic                tgl_seen_d;
	logic                phase_prev_q;
	logic                phase_prev_d;
	logic                strobe_q;
	logic                strobe_d;
	logic [SLOT_W-1:0]   slot_q;
	logic [SLOT_W-1:0]   slot_d;
	logic [LATCH_W-1:0]  latch_q;
	logic [LATCH_W-1:0]  latch_d;
	logic [LATCH_W-1:0]  hold_q;
	logic [LATCH_W-1:0]  hold_d;
	logic [ROWS-1:0]     row_mid_d;
	logic [ROWS-1:0]     row_lvl_d;
	logic [COLS-1:0]     col_d;
	logic                pulse;
	logic                strobe_rise;
	logic [ROWS-1:0]     row_bits;
	logic [COLS-1:0]     col_bits;

	// cap_nib_q is read only after the toggle crosses; it next changes a full
	// link period later, far longer than the synchroniser delay
	always_comb begin
		pulse        = sy_tgl ^ tgl_seen_q;
		tgl_seen_d   = sy_tgl;
		phase_prev_d = sy_phase;
		if (osc_mode) begin
			strobe_d = (sy_phase & ~phase_prev_q) ? ~strobe_q : strobe_q;
		end else begin
			strobe_d = sy_phase;
		end
		strobe_rise = strobe_d & ~strobe_q;

		latch_d = latch_q;
		slot_d  = slot_q;
		if (pulse) begin
			latch_d[{slot_q, 2'b00} +: NIB_W] = cap_nib_q;
			slot_d                           = slot_q + 3'h1;
		end
		hold_d = hold_q;
		if (strobe_rise) begin
			hold_d = latch_d;
			slot_d = SLOT_FIRST;
		end

		if (COL_ONLY) begin
			row_bits = '0;
			col_bits = hold_d;
		end else begin
			row_bits = hold_d[ROWS-1:0];
			col_bits = {{(COLS-COLS_RC){1'b0}}, hold_d[ROWS +: COLS_RC]};
		end

		// A one selects the row; unselected rows rest at the midpoint
		row_mid_d = COL_ONLY ? {ROWS{1'b1}} : ~row_bits;
		row_lvl_d = row_bits & {ROWS{~strobe_d}};
		// Absent columns of the row variant are tied low
		col_d = ~(col_bits ^ {COLS{strobe_d}});
		if (!COL_ONLY) begin
			col_d[COLS-1:COLS_RC] = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_seen_q           <= 1'b0;
			phase_prev_q         <= 1'b0;
			strobe_q             <= 1'b0;
			slot_q               <= SLOT_FIRST;
			latch_q              <= LATCH_RST;
			hold_q               <= LATCH_RST;
			row_mid              <= {ROWS{1'b1}};
			row_lvl              <= '0;
			column_drive_outputs <= '0;
		end else if (ce) begin
			tgl_seen_q           <= tgl_seen_d;
			phase_prev_q         <= phase_prev_d;
			strobe_q             <= strobe_d;
			slot_q               <= slot_d;
			latch_q              <= latch_d;
			hold_q               <= hold_d;
			row_mid              <= row_mid_d;
			row_lvl              <= row_lvl_d;
			column_drive_outputs <= col_d;
		end
	end

	assign lnk.strobe = strobe_q;

endmodule // mld_device

`default_nettype wire

// ===== mld_monitor.sv
// Concurrent checks on the driver link and the drive outputs
`timescale 1ns/1ns
`default_nettype none

module mld_monitor
	import mld_pkg::*;
(
	// Clock and reset
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            osc_mode,
	// Link
	input wire logic            link_clk,
	input wire logic [3:0]      nibble_data_inputs,
	input wire logic            lcd_phase_input,
	input wire logic            strobe,
	input wire logic            refresh_req,
	// Drive outputs
	input wire logic [ROWS-1:0] row_mid,
	input wire logic [ROWS-1:0] row_lvl,
	input wire logic [COLS-1:0] column_drive_outputs
);
	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Phase pin crosses two sync flops and one register
	sequence up3_s; ##3 $rose(strobe); endsequence
	sequence dn3_s; ##3 $fell(strobe); endsequence

	drv_rise_a: assert property (!osc_mode && $rose(lcd_phase_input) |-> up3_s)
		else $error("strobe missed phase rise");
	drv_fall_a: assert property (!osc_mode && $fell(lcd_phase_input) |-> dn3_s)
		else $error("strobe missed phase fall");
	osc_div_a: assert property (osc_mode && $rose(lcd_phase_input) |-> ##3 $changed(strobe))
		else $error("strobe did not toggle on oscillator rise");
	osc_hold_a: assert property (osc_mode && $fell(lcd_phase_input) |-> ##3 $stable(strobe))
		else $error("strobe moved on oscillator fall");
	row_phase_a: assert property ((row_lvl & ~row_mid) == ({ROWS{!strobe}} & ~row_mid))
		else $error("selected row not in antiphase");
	col_flip_a: assert property ($fell(strobe) |-> (column_drive_outputs ^ $past(column_drive_outputs)) == 32'h007f_ffff)
		else $error("columns did not invert with strobe");
	row_keep_a: assert property ($fell(strobe) |-> $stable(row_mid))
		else $error("row selection changed off the strobe rise");
	col_spare_a: assert property (column_drive_outputs[31:23] == 9'h000)
		else $error("absent columns driven");
	nib_edge_a: assert property ($changed(nibble_data_inputs) |-> $rose(link_clk))
		else $error("nibble changed away from clock rise");
	pulse_high_a: assert property ($rose(link_clk) |-> ##125 $fell(link_clk))
		else $error("link clock high time wrong");
	refresh_a: assert property ($rose(strobe) |-> ##[2:4] refresh_req)
		else $error("no refresh request after strobe rise");
endmodule // mld_monitor

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench joining the host loader and the LCD driver
`timescale 1ns/1ns
`default_nettype none

module tb_top
	import mld_pkg::*;
;
	// ********************************
	// Bench
	// ********************************
	localparam int PH  = 3000;
	localparam int OSC = 1500;
	logic            clk = 1'b0;
	logic            rst_n, ce, osc_mode, drive_phase, slot_valid, osc_on;
	logic [31:0]     slot_word;
	logic            slot_ready, refresh_req;
	logic [ROWS-1:0] row_mid, row_lvl;
	logic [COLS-1:0] cols;
	logic [ROWS-1:0] row_mid_c, row_lvl_c;
	logic [COLS-1:0] cols_c;
	int              fail_count = 0;
	int              cmp_count = 0;
	int              osc_cnt = 0;

	mld_link_if lnk ();
	mld_link_if lnk_c ();
	always #2 clk = ~clk;

	// Column-only driver cascaded on the same phase, clock and data lines
	assign lnk_c.link_clk           = lnk.link_clk;
	assign lnk_c.nibble_data_inputs = lnk.nibble_data_inputs;
	assign lnk_c.phase_drv          = lnk.phase_drv;
	assign lnk_c.phase_oe           = lnk.phase_oe;
	assign lnk_c.phase_osc          = lnk.phase_osc;
	mld_device #(.COL_ONLY(1'b1)) i_mld_device_col (.clk(clk), .rst_n(rst_n), .ce(ce), .osc_mode(osc_mode),
		.lnk(lnk_c), .row_mid(row_mid_c), .row_lvl(row_lvl_c), .column_drive_outputs(cols_c));

	mld_host #(.PHASE_HALF_CYC(PH)) i_mld_host (.clk(clk), .rst_n(rst_n), .ce(ce), .drive_phase(drive_phase),
		.slot_word(slot_word), .slot_valid(slot_valid), .slot_ready(slot_ready), .refresh_req(refresh_req), .lnk(lnk));
	mld_device i_mld_device (.clk(clk), .rst_n(rst_n), .ce(ce), .osc_mode(osc_mode), .lnk(lnk),
		.row_mid(row_mid), .row_lvl(row_lvl), .column_drive_outputs(cols));
	mld_monitor i_mld_monitor (.clk(clk), .rst_n(rst_n), .osc_mode(osc_mode), .link_clk(lnk.link_clk),
		.nibble_data_inputs(lnk.nibble_data_inputs), .lcd_phase_input(lnk.lcd_phase_input), .strobe(lnk.strobe),
		.refresh_req(refresh_req), .row_mid(row_mid), .row_lvl(row_lvl), .column_drive_outputs(cols));

	// Stands in for the RC oscillator on the phase pin
	always @(negedge clk) begin
		if (!osc_on) begin
			osc_cnt <= 0;
			lnk.phase_osc <= 1'b0;
		end else if (osc_cnt == OSC - 1) begin
			osc_cnt <= 0;
			lnk.phase_osc <= ~lnk.phase_osc;
		end else osc_cnt <= osc_cnt + 1;
	end

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wait_lvl(input logic v);
		int n;
		for (n = 0; n < 8000 && lnk.strobe !== v; n++) @(negedge clk);
		if (n == 8000) begin
			fail_count++;
			summarize();
		end
	endtask

	// Strobe level s tells which phase the outputs should show
	task automatic chk_out(input logic [31:0] w, input logic s);
		chk("cols", {9'h000, s ? w[30:8] : ~w[30:8]}, cols);
		chk("mid", {24'h0, ~w[7:0]}, {24'h0, row_mid});
		chk("lvl", {24'h0, s ? 8'h00 : w[7:0]}, {24'h0, row_lvl & w[7:0]});
		chk("cols_c", s ? w : ~w, cols_c);
		chk("rows_c", 32'h0000_00ff, {16'h0, row_lvl_c, row_mid_c});
		chk("strobe_c", {31'h0, s}, {31'h0, lnk_c.strobe});
	endtask

	task automatic t_load(input logic [31:0] w);
		int n;
		for (n = 0; n < 8000 && slot_ready !== 1'b1; n++) @(negedge clk);
		if (n == 8000) begin
			fail_count++;
			summarize();
		end
		slot_word = w;
		slot_valid = 1'b1;
		@(negedge clk);
		slot_valid = 1'b0;
		// First rise starts the eight pulses, the second moves them out
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		repeat (2) @(negedge clk);
		chk_out(w, 1'b1);
		wait_lvl(1'b0);
		repeat (2) @(negedge clk);
		chk_out(w, 1'b0);
		$display("load %h done", w);
	endtask

	task automatic t_duty(input int half);
		int n;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		for (n = 0; n < 9000 && lnk.strobe === 1'b1; n++) @(negedge clk);
		chk("high", half, n);
		for (n = 0; n < 9000 && lnk.strobe === 1'b0; n++) @(negedge clk);
		chk("low", half, n);
		$display("duty done");
	endtask

	task automatic t_refresh();
		int k;
		k = 0;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		repeat (2 * PH) begin
			@(negedge clk);
			if (refresh_req === 1'b1) k++;
		end
		chk("refresh", 32'h0000_0001, k);
		$display("refresh done");
	endtask

	task automatic do_reset(input logic osc);
		osc_on = 1'b0;
		rst_n = 1'b0;
		@(negedge clk);
		osc_mode = osc;
		drive_phase = ~osc;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		osc_on = osc;
		$display("reset done");
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		osc_mode = 1'b0;
		drive_phase = 1'b1;
		slot_valid = 1'b0;
		slot_word = 32'h0000_0000;
		osc_on = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_load(32'h5a3c_9601);
		t_load(32'hc3a5_1e80);
		t_duty(PH);
		t_refresh();
		do_reset(1'b1);
		t_load(32'h7e81_2404);
		t_duty(2 * OSC);
		summarize();
	end
endmodule // tb_top

`default_nettype wire
